// ===== rtl/serial_shift_pkg.sv
// ============================================================
// Shared constants and types for the serial shift core
package serial_shift_pkg;

	// ============================================================
	// Register map and data layout
	localparam int DATA_W = 8;
	localparam logic [7:0] SERIAL_SHIFT_DATA_ADDR = 8'h03;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] GET_UNMAPPED = 8'h00;
	localparam int MSB = 7;

	// ============================================================
	// Bit counter
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] COUNT_STEP = 4'h1;
	localparam logic [3:0] BITS_PER_FRAME = 4'h8;

	// ============================================================
	// Buffer in the transmit path
	localparam int FIFO_DEPTH = 32;

	// ============================================================
	// Internal shift clock timing
	localparam int CLK_SYS_NS = 10;
	localparam int SCK_HALF_NS = 400;
	localparam int SCK_HALF_CYCLES = SCK_HALF_NS / CLK_SYS_NS;
	localparam logic [5:0] HALF_ZERO = 6'h00;
	localparam logic [5:0] HALF_STEP = 6'h01;
	localparam logic [5:0] HALF_LAST = 6'(SCK_HALF_CYCLES - 1);
	localparam logic SCK_IDLE = 1'b1;
	localparam logic SO_RESET = 1'b0;

	// ============================================================
	// Types
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} periph_access_t;

	typedef enum logic [0:0] {
		ST_WAIT = 1'b0,
		ST_RUN = 1'b1
	} port_state_t;

endpackage

// ===== rtl/shift_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module shift_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic [AW:0] next_fill;
	logic push;
	logic pop;

	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem[rd_ptr];

	always_comb begin
		next_fill = fill;
		if (push && !pop) begin
			next_fill = fill + 1'b1;
		end else if (pop && !push) begin
			next_fill = fill - 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			fill <= next_fill;
			o_in_ready <= (next_fill != (AW+1)'(DEPTH));
			o_out_valid <= (next_fill != '0);
		end
	end
endmodule // shift_fifo
`default_nettype wire

// ===== rtl/serial_shift_core.sv
`timescale 1ns/1ps
`default_nettype none
module serial_shift_core
	import serial_shift_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_shift_clock_pin,
	input wire logic i_serial_data_in_pin,
	input wire periph_access_t i_put,
	input wire logic i_put_valid,
	output logic o_put_ready,
	input wire logic i_get_valid,
	input wire logic [7:0] i_get_addr,
	output logic [7:0] o_get_data,
	output logic o_get_valid,
	input wire logic i_run_set,
	input wire logic i_run_clear,
	input wire logic i_ce_reset,
	input wire logic i_clock_stop,
	input wire logic i_clock_internal,
	input wire logic i_serial_output_enable,
	input wire logic i_data_out_pin_direction,
	output logic o_transfer_run,
	output logic o_shift_clock_out,
	output logic o_shift_clock_oe,
	output logic o_serial_data_out,
	output logic o_serial_data_out_oe
);

	// ============================================================
	// Helpers
	function automatic logic is_data_addr(input logic [7:0] addr);
		is_data_addr = (addr == SERIAL_SHIFT_DATA_ADDR);
	endfunction

	// ============================================================
	// Declarations
	// Latest cycle after release at which the internal clock has gone low
	localparam int CLOCK_START_MAX = SCK_HALF_CYCLES + 2;
	port_state_t state;
	port_state_t next_state;
	logic si_cap;
	logic si_s1;
	logic si_s2;
	logic sck_s1;
	logic sck_s2;
	logic sck_q;
	logic fall;
	logic rise;
	logic rise_d;
	logic [3:0] count;
	logic [7:0] shift_reg;
	logic slot_busy;
	logic [5:0] half_cnt;
	logic clear_all;
	logic frame_end;
	logic running;
	logic fifo_valid;
	logic fifo_ready;
	logic [7:0] fifo_data;
	logic load;

	// ============================================================
	// Link side: data input taken at the true rising pin edge
	always_ff @(posedge i_shift_clock_pin) begin
		si_cap <= i_serial_data_in_pin;
	end

	// ============================================================
	// Crossing into the system clock
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sck_s1 <= SCK_IDLE;
			sck_s2 <= SCK_IDLE;
			sck_q <= SCK_IDLE;
			si_s1 <= 1'b0;
			si_s2 <= 1'b0;
		end else begin
			sck_s1 <= i_shift_clock_pin;
			sck_s2 <= sck_s1;
			sck_q <= sck_s2;
			si_s1 <= si_cap;
			si_s2 <= si_s1;
		end
	end

	// Edges come from the pin level alone, never from the clock source
	assign fall = sck_q & ~sck_s2;
	assign rise = ~sck_q & sck_s2;

	// Rising work waits one cycle so the captured input has crossed
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rise_d <= 1'b0;
		end else begin
			rise_d <= rise;
		end
	end

	// ============================================================
	// Wait and run control
	assign running = (state == ST_RUN);
	assign clear_all = i_ce_reset | i_clock_stop;
	assign frame_end = running & rise_d & (count == BITS_PER_FRAME);

	always_comb begin
		next_state = state;
		case (state)
			ST_WAIT: begin
				if (i_run_set && !clear_all && !i_run_clear) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (clear_all || i_run_clear) begin
					next_state = ST_WAIT;
				end else if (frame_end) begin
					next_state = ST_WAIT;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state <= ST_WAIT;
			o_transfer_run <= 1'b0;
		end else begin
			state <= next_state;
			o_transfer_run <= (next_state == ST_RUN);
		end
	end

	// ============================================================
	// Bit counter, never visible to software
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			count <= COUNT_ZERO;
		end else if (!running || clear_all || i_run_clear) begin
			count <= COUNT_ZERO;
		end else if (frame_end) begin
			count <= COUNT_ZERO;
		end else if (fall) begin
			count <= count + COUNT_STEP;
		end
	end

	// ============================================================
	// Transmit buffer; the next byte is loaded in wait once the data has been read
	shift_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_in_valid(i_put_valid & is_data_addr(i_put.addr)),
		.i_in_data(i_put.data),
		.o_in_ready(o_put_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_ready)
	);

	// Load only in wait, and only once the last byte has been read
	assign fifo_ready = ~running & ~slot_busy;
	assign load = fifo_valid & fifo_ready;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			slot_busy <= 1'b0;
		end else if (load) begin
			slot_busy <= 1'b1;
		end else if (i_get_valid && is_data_addr(i_get_addr) && !running) begin
			slot_busy <= 1'b0;
		end
	end

	// ============================================================
	// Shift register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			shift_reg <= SHIFT_RESET;
		end else if (load) begin
			shift_reg <= fifo_data;
		end else if (running && rise_d) begin
			shift_reg <= {shift_reg[MSB-1:0], si_s2};
		end
	end

	// ============================================================
	// Serial data output pin
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_serial_data_out <= SO_RESET;
		end else if (running && fall) begin
			o_serial_data_out <= shift_reg[MSB];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_serial_data_out_oe <= 1'b0;
		end else begin
			o_serial_data_out_oe <= i_serial_output_enable &
				i_data_out_pin_direction;
		end
	end

	// ============================================================
	// Internal shift clock, high whenever the port waits
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_shift_clock_out <= SCK_IDLE;
			half_cnt <= HALF_ZERO;
		end else if (next_state != ST_RUN || !i_clock_internal) begin
			o_shift_clock_out <= SCK_IDLE;
			half_cnt <= HALF_ZERO;
		end else if (count == BITS_PER_FRAME && o_shift_clock_out) begin
			half_cnt <= HALF_ZERO;
		end else if (half_cnt == HALF_LAST) begin
			o_shift_clock_out <= ~o_shift_clock_out;
			half_cnt <= HALF_ZERO;
		end else begin
			half_cnt <= half_cnt + HALF_STEP;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_shift_clock_oe <= 1'b0;
		end else begin
			o_shift_clock_oe <= i_clock_internal;
		end
	end

	// ============================================================
	// Data read straight from the shift register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_get_valid <= 1'b0;
			o_get_data <= GET_UNMAPPED;
		end else begin
			o_get_valid <= i_get_valid;
			if (i_get_valid) begin
				o_get_data <= is_data_addr(i_get_addr) ?
					shift_reg : GET_UNMAPPED;
			end
		end
	end

	// ============================================================
	// Checks
	a_count_after_reset: assert property (
		@(posedge i_clk_sys)
		!i_rst_n |=> count == COUNT_ZERO
	) else $error("bit counter not zero after reset");

	a_count_on_fall: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		running && fall && !rise_d && !clear_all && !i_run_clear
		|=> count == $past(count) + COUNT_STEP
	) else $error("bit counter missed a falling edge");

	a_wrap_to_wait: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		running && rise_d && count == BITS_PER_FRAME
		|=> count == COUNT_ZERO && state == ST_WAIT
	) else $error("counter did not wrap into wait after eight");

	a_flag_self_clear: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		frame_end && !i_run_set |=> !o_transfer_run ##1 !o_transfer_run
	) else $error("run flag not cleared at frame end");

	a_ce_stop_clear: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		clear_all |=> count == COUNT_ZERO && !o_transfer_run
	) else $error("counter or flag survived clock stop or CE reset");

	a_forced_wait: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		running && i_run_clear |=> state == ST_WAIT && count == COUNT_ZERO
	) else $error("forced wait did not clear the counter");

	a_frozen_in_wait: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!running && !load |=> shift_reg == $past(shift_reg)
	) else $error("shift register moved while waiting");

	a_msb_to_pin: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		running && fall |=> o_serial_data_out == $past(shift_reg[MSB])
	) else $error("MSB not driven at falling edge");

	a_lsb_from_pin: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		running && rise_d && !load |=> shift_reg[0] == $past(si_s2)
	) else $error("input bit not captured into LSB");

	a_output_gated: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_serial_output_enable |=> !o_serial_data_out_oe
	) else $error("serial output driven while disabled");

	a_clock_high_wait: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!running && !i_run_set ##1 !running |-> o_shift_clock_out
	) else $error("shift clock low during wait");

	a_clock_starts: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!running && i_run_set && !i_run_clear && !clear_all &&
		i_clock_internal |-> ##[1:CLOCK_START_MAX]
		(!o_shift_clock_out || !running || !i_clock_internal)
	) else $error("internal clock did not start after release");

endmodule // serial_shift_core
`default_nettype wire

// ===== verif/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input wire logic i_sck,
	input wire logic i_so,
	input wire logic i_start,
	input wire logic i_gen,
	input wire logic [7:0] i_tx,
	output logic o_sck,
	output logic o_si,
	output logic [7:0] o_rx
);
	logic [7:0] sh;
	int n;
	initial begin
		o_sck = 1'b1;
		o_si = 1'b0;
		o_rx = 8'h00;
		sh = 8'h00;
		n = 8;
	end
	// ============================================================
	// Frame start; in slave mode eight clocks, still between frames
	always @(posedge i_start) begin
		sh = i_tx;
		n = 0;
		if (i_gen) begin
			#13;
			repeat (8) begin
				#40 o_sck = 1'b0;
				#40 o_sck = 1'b1;
			end
		end
	end
	// Outside a frame the data line toggles instead of holding
	always @(negedge i_sck) begin
		o_si = (n < 8) ? sh[7 - n] : ~o_si;
		n = n + 1;
	end
	always @(posedge i_sck)
		o_rx = {o_rx[6:0], i_so};
endmodule // serial_peer
`default_nettype wire

// ===== verif/serial_shift_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_shift_core_bench
	import serial_shift_pkg::*;
;
	logic clk, rst_n, put_valid, get_valid, run_set, run_clear;
	logic ce_reset, clock_stop, internal, out_en, start, gen, got;
	logic run, sck_out, sck_oe, so, so_oe, put_ready, si, peer_sck;
	logic sck, so_w, ok, dir;
	periph_access_t put;
	logic [7:0] get_addr, get_data, peer_tx, peer_rx, tx, b;
	int fail_count, checked, i, n;
	logic [31:0] seed;
	logic [7:0] sent_q[$];

	always #5 clk = ~clk;
	assign sck = sck_oe ? sck_out : peer_sck;
	assign so_w = so_oe ? so : ~so;

	serial_shift_core u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_shift_clock_pin(sck), .i_serial_data_in_pin(si), .i_put(put),
		.i_put_valid(put_valid), .o_put_ready(put_ready),
		.i_get_valid(get_valid), .i_get_addr(get_addr),
		.o_get_data(get_data), .o_get_valid(got), .i_run_set(run_set),
		.i_run_clear(run_clear), .i_ce_reset(ce_reset),
		.i_clock_stop(clock_stop), .i_clock_internal(internal),
		.i_serial_output_enable(out_en), .i_data_out_pin_direction(dir),
		.o_transfer_run(run), .o_shift_clock_out(sck_out),
		.o_shift_clock_oe(sck_oe), .o_serial_data_out(so),
		.o_serial_data_out_oe(so_oe));
	serial_peer u_peer (.i_sck(sck), .i_so(so_w), .i_start(start),
		.i_gen(gen), .i_tx(peer_tx), .o_sck(peer_sck), .o_si(si),
		.o_rx(peer_rx));

	// ============================================================
	// Helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input bit good, input string msg);
		checked++;
		if (!good) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
		int k;
		@(negedge clk);
		put.addr = a;
		put.data = d;
		put_valid = 1'b1;
		k = 0;
		while (put_ready !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		ok = (put_ready === 1'b1);
		if (ok && a == SERIAL_SHIFT_DATA_ADDR)
			sent_q.push_back(d);
		@(negedge clk);
		put_valid = 1'b0;
	endtask
	task automatic get_check(input logic [7:0] a, input logic [7:0] exp,
			input bit chk);
		@(negedge clk);
		get_addr = a;
		get_valid = 1'b1;
		@(negedge clk);
		get_valid = 1'b0;
		if (chk)
			check(got === 1'b1 && get_data === exp, "read data");
	endtask
	// Releases wait and waits for the run flag to drop
	task automatic frame(input bit master, input logic [7:0] d);
		int k;
		@(negedge clk);
		internal = master;
		peer_tx = d;
		gen = !master;
		pulse(run_set);
		check(run === 1'b1, "run flag not set");
		pulse(start);
		k = 0;
		while (run !== 1'b0 && k < 1500) begin
			@(negedge clk);
			k++;
			if (!(out_en && dir))
				check(so_oe === 1'b0, "output not off");
		end
		if (k >= 1500) begin
			check(1'b0, "run flag never cleared");
			stop_test();
		end
		check(sck === 1'b1, "clock not high in wait");
	endtask

	// ============================================================
	// Main sequence
	initial begin
		clk = 0; rst_n = 0; put = '0; put_valid = 0; get_valid = 0;
		get_addr = 0; run_set = 0; run_clear = 0; ce_reset = 0;
		clock_stop = 0; internal = 1; out_en = 1; start = 0; gen = 0;
		peer_tx = 0; fail_count = 0; checked = 0; seed = 32'h8e1b_bfc4;
		dir = 1;
		repeat (6) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		check(run === 1'b0 && sck_out === 1'b1, "reset state");
		get_check(8'h05, GET_UNMAPPED, 1);
		$display("test reset done");
		put_byte(8'h05, 8'hff);
		put_byte(SERIAL_SHIFT_DATA_ADDR, rnd());
		repeat (4) @(negedge clk);
		n = 0;
		do begin
			put_byte(SERIAL_SHIFT_DATA_ADDR, rnd());
			n += ok;
		end while (ok && n < 40);
		check(n == FIFO_DEPTH, "buffer depth");
		$display("test fill done");
		for (i = 0; sent_q.size() > 0; i++) begin
			tx = rnd();
			out_en = (i != 3);
			dir = (i != 9);
			if (i == 5) begin
				pulse(ce_reset);
				pulse(clock_stop);
			end
			frame(i[0] == 0, tx);
			b = sent_q.pop_front();
			if (out_en && dir)
				check(peer_rx === b && so_oe === 1'b1, "sent byte");
			if (i == 7) begin
				peer_tx = ~tx;
				pulse(start);
				repeat (100) @(negedge clk);
			end
			get_check(SERIAL_SHIFT_DATA_ADDR, tx, 1);
		end
		$display("test drain done");
		put_byte(SERIAL_SHIFT_DATA_ADDR, rnd());
		repeat (4) @(negedge clk);
		internal = 1;
		pulse(run_set);
		repeat (200) @(negedge clk);
		pulse(run_clear);
		check(run === 1'b0, "forced wait");
		b = rnd();
		put_byte(SERIAL_SHIFT_DATA_ADDR, b);
		get_check(SERIAL_SHIFT_DATA_ADDR, 8'h00, 0);
		void'(sent_q.pop_front());
		tx = rnd();
		frame(1, tx);
		check(peer_rx === sent_q.pop_front(), "after forced wait");
		get_check(SERIAL_SHIFT_DATA_ADDR, tx, 1);
		$display("test forced wait done");
		stop_test();
	end
endmodule // serial_shift_core_bench
`default_nettype wire
